// ### sbwu_ctrl.sv
`timescale 1ns/100ps
module sbwu_ctrl import sbwu_pkg::*; #(
  parameter int N_IRQ = 16,
  parameter logic [11:0] PLL_LOCK_TICKS = 12'h0c8
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic cmd_valid,
  input wire logic [1:0] cmd_kind,
  input wire logic [2:0] cmd_mode,
  input wire logic cmd_to_normal,
  input wire logic cmd_use_pll,
  input wire logic cmd_prio_mask_only,
  input wire logic [N_IRQ-1:0] cmd_wake_mask,
  input wire logic [11:0] cmd_settle_upper,
  input wire logic [1:0] cmd_settle_lower,
  input wire logic wake_req,
  input wire logic [1:0] osc_clock_select,
  input wire logic handling_started,
  input wire logic warmup_done,
  output logic busy,
  output logic cmd_done,
  output logic cmd_error,
  output logic [2:0] standby_mode,
  output logic warmup_src_sel_a,
  output logic warmup_src_sel_b,
  output logic [11:0] warmup_time_upper,
  output logic [1:0] warmup_time_lower,
  output logic cfg_write,
  output logic [N_IRQ-1:0] irq_enable,
  output logic watchdog_stop,
  output logic voltage_detect_stop,
  output logic ofd_reset_disable,
  output logic watchdog_reset_disable,
  output logic wfi_pulse,
  output logic ext_wake_interrupt,
  output logic dev_reset_n,
  output logic low_osc_enable,
  output logic high_osc_enable,
  output logic warmup_start
);
  // =====================================================
  // Elaboration check
  if (N_IRQ < 1 || N_IRQ > 256) begin : g_bad_nirq
    $error("N_IRQ out of range");
  end

  typedef struct packed {
    sbwu_state_t st;
    logic [11:0] cnt;
    logic pmo;
    logic busy;
    logic done;
    logic err;
    logic [2:0] mode;
    logic wup_a;
    logic wup_b;
    logic [11:0] wu_up;
    logic [1:0] wu_lo;
    logic cfg_wr;
    logic [N_IRQ-1:0] irq_en;
    logic wdt_stop;
    logic vltd_stop;
    logic ofd_rdis;
    logic wdt_rdis;
    logic wait_for_interrupt_instr;
    logic wake;
    logic rst_n_out;
    logic lso_en;
    logic hso_en;
    logic warm;
  } sbwu_regs_t;

  sbwu_regs_t r;
  sbwu_regs_t next_r;

  function automatic logic sbwu_legal_mode(input logic [2:0] m);
    return (m == SBWU_MODE_STOP) || (m == SBWU_MODE_SLEEP) || (m == SBWU_MODE_IDLE);
  endfunction : sbwu_legal_mode

  logic [12:0] pll_sum;
  assign pll_sum = {1'b0, cmd_settle_upper} + {1'b0, PLL_LOCK_TICKS};

  // =====================================================
  // Sequencer
  always_comb begin
    next_r = r;
    next_r.done = 1'b0;
    next_r.cfg_wr = 1'b0;
    next_r.wait_for_interrupt_instr = 1'b0;
    next_r.warm = 1'b0;
    case (r.st)
      SBWU_S_IDLE: begin
        next_r.busy = 1'b0;
        if (cmd_valid) begin
          next_r.err = 1'b0;
          next_r.busy = 1'b1;
          if (cmd_kind == SBWU_CMD_STANDBY) begin
            if (sbwu_legal_mode(cmd_mode)) begin
              next_r.st = SBWU_S_CFG;
              next_r.mode = cmd_mode;
              next_r.pmo = cmd_prio_mask_only;
              next_r.irq_en = cmd_wake_mask;
              next_r.wup_a = osc_clock_select[0];
              next_r.wup_b = osc_clock_select[1];
              next_r.wu_lo = cmd_settle_lower;
              if (cmd_mode == SBWU_MODE_STOP && cmd_use_pll) begin
                // Saturate so a long settle never wraps to a short warm-up
                next_r.wu_up = pll_sum[12] ? SBWU_WU_MAX : pll_sum[11:0];
              end else begin
                next_r.wu_up = cmd_settle_upper;
              end
              if (cmd_mode != SBWU_MODE_IDLE) begin
                next_r.wdt_stop = 1'b1;
                next_r.vltd_stop = 1'b1;
                next_r.ofd_rdis = 1'b1;
                next_r.wdt_rdis = 1'b1;
              end else begin
                next_r.wdt_stop = 1'b0;
                next_r.vltd_stop = 1'b0;
                next_r.ofd_rdis = 1'b0;
                next_r.wdt_rdis = 1'b0;
              end
            end else begin
              next_r.err = 1'b1;
              next_r.done = 1'b1;
              next_r.busy = 1'b0;
            end
          end else if (cmd_kind == SBWU_CMD_RUNSW) begin
            // Oscillator first; warm-up starts only once it is enabled
            next_r.st = SBWU_S_WARM;
            next_r.cnt = SBWU_CNT_ZERO;
            if (cmd_to_normal) begin
              next_r.hso_en = 1'b1;
            end else begin
              next_r.lso_en = 1'b1;
            end
          end else if (cmd_kind == SBWU_CMD_COLDRST) begin
            next_r.st = SBWU_S_RST;
            next_r.rst_n_out = 1'b0;
            next_r.cnt = SBWU_RST_HOLD_CYC;
          end else begin
            next_r.err = 1'b1;
            next_r.done = 1'b1;
            next_r.busy = 1'b0;
          end
        end
      end
      SBWU_S_CFG: begin
        next_r.cfg_wr = 1'b1;
        next_r.st = SBWU_S_WFI;
      end
      SBWU_S_WFI: begin
        next_r.wait_for_interrupt_instr = 1'b1;
        next_r.cnt = SBWU_NOP_MIN;
        next_r.st = r.pmo ? SBWU_S_NOP : SBWU_S_WAIT;
      end
      SBWU_S_NOP: begin
        // No real work until the pending-request window has passed
        next_r.cnt = r.cnt - SBWU_CNT_ONE;
        if (r.cnt == SBWU_CNT_ONE) begin
          next_r.st = SBWU_S_WAIT;
        end
      end
      SBWU_S_WAIT: begin
        if (wake_req) begin
          next_r.wake = 1'b1;
          next_r.st = SBWU_S_HOLD;
        end
      end
      SBWU_S_HOLD: begin
        if (handling_started) begin
          next_r.wake = 1'b0;
          next_r.done = 1'b1;
          next_r.st = SBWU_S_IDLE;
        end
      end
      SBWU_S_WARM: begin
        if (!r.warm && r.cnt == SBWU_CNT_ZERO) begin
          next_r.warm = 1'b1;
          next_r.cnt = SBWU_CNT_ONE;
        end else if (warmup_done && !r.warm) begin
          next_r.cnt = SBWU_CNT_ZERO;
          next_r.done = 1'b1;
          next_r.st = SBWU_S_IDLE;
        end
      end
      SBWU_S_RST: begin
        next_r.cnt = r.cnt - SBWU_CNT_ONE;
        if (r.cnt == SBWU_CNT_ONE) begin
          next_r.rst_n_out = 1'b1;
          next_r.wdt_stop = 1'b0;
          next_r.vltd_stop = 1'b0;
          next_r.ofd_rdis = 1'b0;
          next_r.wdt_rdis = 1'b0;
          next_r.wake = 1'b0;
          next_r.done = 1'b1;
          next_r.st = SBWU_S_IDLE;
        end
      end
      default: begin
        next_r.st = SBWU_S_IDLE;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      r <= '0;
      r.st <= SBWU_S_IDLE;
      r.rst_n_out <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign busy = r.busy;
  assign cmd_done = r.done;
  assign cmd_error = r.err;
  assign standby_mode = r.mode;
  assign warmup_src_sel_a = r.wup_a;
  assign warmup_src_sel_b = r.wup_b;
  assign warmup_time_upper = r.wu_up;
  assign warmup_time_lower = r.wu_lo;
  assign cfg_write = r.cfg_wr;
  assign irq_enable = r.irq_en;
  assign watchdog_stop = r.wdt_stop;
  assign voltage_detect_stop = r.vltd_stop;
  assign ofd_reset_disable = r.ofd_rdis;
  assign watchdog_reset_disable = r.wdt_rdis;
  assign wfi_pulse = r.wait_for_interrupt_instr;
  assign ext_wake_interrupt = r.wake;
  assign dev_reset_n = r.rst_n_out;
  assign low_osc_enable = r.lso_en;
  assign high_osc_enable = r.hso_en;
  assign warmup_start = r.warm;

  // =====================================================
  // Checks
  sequence seq_entry;
    cfg_write ##1 wfi_pulse;
  endsequence

  sequence seq_nops;
    (r.st == SBWU_S_NOP) [*8];
  endsequence

  AST_MODE_LEGAL: assert property (@(posedge clock) disable iff (!rst_n)
    wfi_pulse |-> sbwu_legal_mode(standby_mode)) else $error("illegal standby mode at entry");
  AST_CFG_FIRST: assert property (@(posedge clock) disable iff (!rst_n)
    r.st == SBWU_S_CFG |=> seq_entry) else $error("config not written before wait");
  AST_SRC_MATCH: assert property (@(posedge clock) disable iff (!rst_n)
    (r.st == SBWU_S_IDLE && cmd_valid && cmd_kind == SBWU_CMD_STANDBY && sbwu_legal_mode(cmd_mode))
    |=> {warmup_src_sel_b, warmup_src_sel_a} == $past(osc_clock_select)) else $error("warm-up source mismatch");
  AST_NMI_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    wfi_pulse && standby_mode != SBWU_MODE_IDLE |-> watchdog_stop && voltage_detect_stop)
    else $error("NMI sources live at deep entry");
  AST_RST_OFF: assert property (@(posedge clock) disable iff (!rst_n)
    wfi_pulse && standby_mode != SBWU_MODE_IDLE |-> ofd_reset_disable && watchdog_reset_disable)
    else $error("resets live at deep entry");
  AST_MASK_STABLE: assert property (@(posedge clock) disable iff (!rst_n)
    seq_entry |-> $stable(irq_enable)) else $error("mask changed during entry");
  AST_NOPS: assert property (@(posedge clock) disable iff (!rst_n)
    wfi_pulse && r.pmo |-> seq_nops ##1 (r.st == SBWU_S_WAIT)) else $error("no-op window wrong");
  AST_WAKE_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    ext_wake_interrupt && !handling_started |=> ext_wake_interrupt) else $error("wake level dropped early");
  AST_RST_HOLD: assert property (@(posedge clock) disable iff (!rst_n)
    $fell(dev_reset_n) |-> (!dev_reset_n) [*8]) else $error("reset released too soon");
  AST_WARM_AFTER_OSC: assert property (@(posedge clock) disable iff (!rst_n)
    $rose(warmup_start) |-> $past(high_osc_enable || low_osc_enable)) else $error("warm-up before oscillator");
endmodule : sbwu_ctrl

// ### sbwu_ctrl_test.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin checks++; if ((g) !== (e)) begin n_errors++; $display("Error %s expected %h seen %h", nm, e, g); end end
module sbwu_ctrl_test;
  import sbwu_pkg::*;
  localparam logic [11:0] LOCK = 12'h0c8;
  logic clock = 1'b0, rst_n = 1'b0, cmd_valid = 1'b0, cmd_to_normal = 1'b0, cmd_use_pll = 1'b0;
  logic cmd_prio_mask_only = 1'b0, fire = 1'b0;
  logic [1:0] cmd_kind = 2'h0, osc_clock_select = 2'h0, fire_src = 2'h0, cmd_settle_lower = 2'h0;
  logic [2:0] cmd_mode = 3'h0;
  logic [15:0] cmd_wake_mask = 16'h0000;
  logic [11:0] cmd_settle_upper = 12'h000;
  logic wake_req, handling_started, warmup_done, busy, cmd_done, cmd_error, warmup_src_sel_a, warmup_src_sel_b;
  logic cfg_write, watchdog_stop, voltage_detect_stop, ofd_reset_disable, watchdog_reset_disable;
  logic wfi_pulse, ext_wake_interrupt, dev_reset_n, low_osc_enable, high_osc_enable, warmup_start;
  logic [2:0] standby_mode;
  logic [11:0] warmup_time_upper;
  logic [1:0] warmup_time_lower;
  logic [15:0] irq_enable;
  logic [21:0] exp_now = 22'h000000;
  logic [21:0] expq[$];
  integer seed = 88729, n_errors = 0, checks = 0;
  wire [21:0] seen = {cmd_error, standby_mode, warmup_time_upper, warmup_time_lower,
    watchdog_stop, voltage_detect_stop, ofd_reset_disable, watchdog_reset_disable};
  always #2.5 clock = ~clock;
  sbwu_ctrl #(.N_IRQ(16), .PLL_LOCK_TICKS(LOCK)) u_sbwu_ctrl (.clock, .rst_n, .cmd_valid, .cmd_kind,
    .cmd_mode, .cmd_to_normal, .cmd_use_pll, .cmd_prio_mask_only, .cmd_wake_mask, .cmd_settle_upper,
    .cmd_settle_lower, .wake_req, .osc_clock_select, .handling_started, .warmup_done, .busy, .cmd_done,
    .cmd_error, .standby_mode, .warmup_src_sel_a, .warmup_src_sel_b, .warmup_time_upper, .warmup_time_lower,
    .cfg_write, .irq_enable, .watchdog_stop, .voltage_detect_stop, .ofd_reset_disable,
    .watchdog_reset_disable, .wfi_pulse, .ext_wake_interrupt, .dev_reset_n, .low_osc_enable,
    .high_osc_enable, .warmup_start);
  sbwu_dev_model u_sbwu_dev_model (.clock, .rst_n, .fire, .fire_src, .standby_mode, .wfi_pulse,
    .warmup_time_upper, .warmup_time_lower, .ext_wake_interrupt, .dev_reset_n, .warmup_start,
    .high_osc_enable, .wake_req, .handling_started, .warmup_done);
  // ==========
  // Command driver: notes the expected end state, then walks the handshake
  task automatic issue(input logic [1:0] k, input logic [2:0] m, input logic [11:0] u, input logic pll,
    input logic [1:0] src);
    logic [12:0] up;
    logic tn;
    logic [1:0] lw;
    logic sb;
    int n;
    tn = 1'($random(seed));
    lw = 2'($random(seed));
    sb = k == SBWU_CMD_STANDBY && m != 3'h0 && m < 3'h4;
    up = {1'b0, u} + ((pll && m == SBWU_MODE_STOP) ? {1'b0, LOCK} : 13'h0000);
    exp_now[21] = k == 2'h3 || (k == SBWU_CMD_STANDBY && !sb);
    if (sb) exp_now[20:0] = {m, up[12] ? 12'hfff : up[11:0], lw, {4{m != SBWU_MODE_IDLE}}};
    if (k == SBWU_CMD_COLDRST) exp_now[3:0] = 4'h0;
    expq.push_back(exp_now);
    @(posedge clock);
    cmd_valid <= 1'b1;
    cmd_kind <= k;
    cmd_mode <= m;
    cmd_settle_upper <= u;
    cmd_settle_lower <= lw;
    cmd_use_pll <= pll;
    cmd_to_normal <= tn;
    cmd_prio_mask_only <= 1'($random(seed));
    cmd_wake_mask <= 16'($random(seed));
    osc_clock_select <= 2'($random(seed));
    @(posedge clock);
    cmd_valid <= 1'b0;
    @(posedge clock);
    #1;
    if (k == SBWU_CMD_COLDRST) `CHK("reset", 1'b0, dev_reset_n)
    if (k == SBWU_CMD_RUNSW) `CHK("osc", 1'b1, tn ? high_osc_enable : low_osc_enable)
    if (k == SBWU_CMD_RUNSW) `CHK("warm start", 1'b1, warmup_start)
    if (sb) begin
      `CHK("cfg write", 1'b1, cfg_write)
      @(posedge clock);
      #1;
      `CHK("wfi", 1'b1, wfi_pulse)
      `CHK("irq en", cmd_wake_mask, irq_enable)
      `CHK("src sel", osc_clock_select, {warmup_src_sel_b, warmup_src_sel_a})
      repeat (12) @(posedge clock);
      fire_src <= src;
      fire <= 1'b1;
      @(posedge clock);
      fire <= 1'b0;
      // A tick or watchdog source must leave sleep and stop untouched
      if (src != 2'h0 && m != SBWU_MODE_IDLE) begin
        repeat (20) @(posedge clock);
        #1;
        `CHK("no wake", 1'b1, busy)
        `CHK("no wake irq", 1'b0, ext_wake_interrupt)
        @(posedge clock);
        fire_src <= 2'h0;
        fire <= 1'b1;
        @(posedge clock);
        fire <= 1'b0;
      end
    end
    n = 0;
    while (busy !== 1'b0 && n < 20000) begin
      @(posedge clock);
      #1;
      n++;
    end
    // A command that never finishes ends the run here
    if (busy !== 1'b0) begin
      n_errors++;
      summarize;
    end
    if (k == SBWU_CMD_COLDRST) `CHK("reset off", 1'b1, dev_reset_n)
  endtask : issue
  always @(posedge clock) begin
    #1;
    if (cmd_done === 1'b1) begin
      `CHK("done state", expq.size() > 0 ? expq[0] : 22'h3fffff, seen)
      if (expq.size() > 0) void'(expq.pop_front());
    end
  end
  task summarize;
    if (n_errors == 0 && checks > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask : summarize
  initial begin
    #400000;
    n_errors++;
    summarize;
  end
  initial begin
    repeat (10) @(posedge clock);
    rst_n <= 1'b1;
    issue(SBWU_CMD_RUNSW, SBWU_MODE_NONE, 12'h004, 1'b0, 2'h0);
    issue(SBWU_CMD_STANDBY, SBWU_MODE_IDLE, 12'h005, 1'b0, 2'h1);
    issue(SBWU_CMD_STANDBY, SBWU_MODE_IDLE, 12'h006, 1'b1, 2'h2);
    issue(SBWU_CMD_STANDBY, SBWU_MODE_SLEEP, 12'h007, 1'b1, 2'h1);
    issue(SBWU_CMD_STANDBY, SBWU_MODE_STOP, 12'hf80, 1'b1, 2'h2);
    issue(SBWU_CMD_STANDBY, SBWU_MODE_STOP, 12'h009, 1'b0, 2'h0);
    for (int i = 0; i < 8; i++) if (i == 0 || i > 3) issue(SBWU_CMD_STANDBY, 3'(i), 12'h00a, 1'b0, 2'h0);
    issue(2'h3, SBWU_MODE_IDLE, 12'h00b, 1'b0, 2'h0);
    issue(SBWU_CMD_COLDRST, SBWU_MODE_NONE, 12'h00c, 1'b0, 2'h0);
    issue(SBWU_CMD_STANDBY, SBWU_MODE_SLEEP, 12'h00d, 1'b0, 2'h0);
    repeat (4) @(posedge clock);
    `CHK("notes left", 0, expq.size())
    summarize;
  end
endmodule : sbwu_ctrl_test

// ### sbwu_dev_model.sv
`timescale 1ns/100ps
// ==========
// Device model: standby modes, release sources, warm-up counter
module sbwu_dev_model import sbwu_pkg::*; (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic fire,
  input wire logic [1:0] fire_src,
  input wire logic [2:0] standby_mode,
  input wire logic wfi_pulse,
  input wire logic [11:0] warmup_time_upper,
  input wire logic [1:0] warmup_time_lower,
  input wire logic ext_wake_interrupt,
  input wire logic dev_reset_n,
  input wire logic warmup_start,
  input wire logic high_osc_enable,
  output logic wake_req,
  output logic handling_started,
  output logic warmup_done
);
  logic [2:0] mode;
  logic sw;
  logic [13:0] cnt;
  // Source 0 is an external pin, 1 the tick, 2 the watchdog; only pins reach sleep/stop
  always @(posedge clock) begin
    if (!rst_n || !dev_reset_n) begin
      mode <= SBWU_MODE_NONE;
      sw <= 1'b0;
      cnt <= 14'h0000;
      wake_req <= 1'b0;
      handling_started <= 1'b0;
      warmup_done <= 1'b0;
    end else begin
      if (cnt != 14'h0000) cnt <= cnt - 14'h0001;
      if (wfi_pulse && !wake_req) mode <= standby_mode;
      if (fire && (fire_src == 2'h0 || mode == SBWU_MODE_IDLE)) wake_req <= 1'b1;
      if (wake_req && mode != SBWU_MODE_NONE) begin
        mode <= SBWU_MODE_NONE;
        // Slow return from sleep keeps the low oscillator running, so no count
        if (mode == SBWU_MODE_STOP || (mode == SBWU_MODE_SLEEP && high_osc_enable)) begin
          cnt <= {warmup_time_upper, warmup_time_lower};
        end
      end
      if (warmup_start) begin
        sw <= 1'b1;
        warmup_done <= 1'b0;
        cnt <= {warmup_time_upper, warmup_time_lower};
      end else if (sw && cnt == 14'h0000) begin
        sw <= 1'b0;
        warmup_done <= 1'b1;
      end
      if (mode == SBWU_MODE_NONE && wake_req && ext_wake_interrupt && cnt == 14'h0000) begin
        handling_started <= 1'b1;
        wake_req <= 1'b0;
      end
      if (!ext_wake_interrupt) handling_started <= 1'b0;
    end
  end
endmodule : sbwu_dev_model

// ### sbwu_pkg.sv
package sbwu_pkg;
  // =====================================================
  // Standby mode codes written to the standby control field
  localparam logic [2:0] SBWU_MODE_STOP = 3'h1;
  localparam logic [2:0] SBWU_MODE_SLEEP = 3'h2;
  localparam logic [2:0] SBWU_MODE_IDLE = 3'h3;
  localparam logic [2:0] SBWU_MODE_NONE = 3'h0;
  // =====================================================
  // Command kinds on the user port
  localparam logic [1:0] SBWU_CMD_STANDBY = 2'h0;
  localparam logic [1:0] SBWU_CMD_RUNSW = 2'h1;
  localparam logic [1:0] SBWU_CMD_COLDRST = 2'h2;
  // =====================================================
  // Timing
  localparam int SBWU_CLK_PERIOD_NS = 5;
  localparam int SBWU_RST_HOLD_NS = 10000;
  localparam logic [11:0] SBWU_RST_HOLD_CYC =
    12'((SBWU_RST_HOLD_NS + SBWU_CLK_PERIOD_NS - 1) / SBWU_CLK_PERIOD_NS);
  localparam logic [11:0] SBWU_NOP_MIN = 12'h008;
  localparam logic [11:0] SBWU_CNT_ZERO = 12'h000;
  localparam logic [11:0] SBWU_CNT_ONE = 12'h001;
  localparam logic [11:0] SBWU_WU_MAX = 12'hfff;
  // =====================================================
  // Sequencer states, one-hot
  typedef enum logic [7:0] {
    SBWU_S_IDLE = 8'h01,
    SBWU_S_CFG = 8'h02,
    SBWU_S_WFI = 8'h04,
    SBWU_S_NOP = 8'h08,
    SBWU_S_WAIT = 8'h10,
    SBWU_S_HOLD = 8'h20,
    SBWU_S_WARM = 8'h40,
    SBWU_S_RST = 8'h80
  } sbwu_state_t;
endpackage : sbwu_pkg
